/* File: rxd_pkg.sv */
package rxd_pkg;
    // Widths
    localparam int AXW = 8;
    localparam int HP_W = 5;
    localparam int LP_W = 16;
    localparam int HP_SHIFT = LP_W - HP_W;
    localparam int NSTG = 10;
    localparam int ACC_W = 21;
    localparam int CAL_LOG2 = 8;
    // Register byte offsets
    localparam logic [AXW-1:0] A_CTRL = 8'h00;
    localparam logic [AXW-1:0] A_DEC = 8'h04;
    localparam logic [AXW-1:0] A_NCO = 8'h08;
    localparam logic [AXW-1:0] A_NOTCH = 8'h0C;
    localparam logic [AXW-1:0] A_QEC = 8'h10;
    localparam logic [AXW-1:0] A_STAT = 8'h14;
    localparam logic [AXW-1:0] A_CDC = 8'h18;
    // Control field positions
    localparam int C_CONV = 0;
    localparam int C_WB = 1;
    localparam int C_IF = 2;
    localparam int C_R61 = 3;
    localparam int C_SWEN = 4;
    localparam int C_CAL = 5;
    localparam int C_CLK = 6;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] DEC_RST = 7'h7F;
    localparam logic [3:0] NOTCH_RST = 4'hB;
    localparam logic [15:0] QEC_RST = 16'h0000;
    localparam logic [15:0] QEC_STEP = 16'h0004;
    // Decimation factors
    localparam logic [3:0] F_CLK_H = 4'hC;
    localparam logic [3:0] F_CLK_M = 4'h8;
    localparam logic [3:0] F_CLK_L = 4'h6;
    localparam logic [3:0] F_61 = 4'h3;
    localparam logic [3:0] F_46 = 4'h4;
    localparam logic [3:0] F_10 = 4'hA;
    localparam logic [3:0] F_3 = 4'h3;
    localparam logic [3:0] F_2 = 4'h2;
    // Oscillator tuning limits, word scaled to the 184.32 MHz rate
    localparam longint RATE1_HZ = 184320000;
    localparam longint NCO_MIN_HZ = 45000;
    localparam longint NCO_MAX_HZ = 21000000;
    localparam logic [31:0] FTW_MIN = 32'((NCO_MIN_HZ << 32) / RATE1_HZ);
    localparam logic [31:0] FTW_MAX = 32'((NCO_MAX_HZ << 32) / RATE1_HZ);
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef struct packed {
        logic signed [LP_W-1:0] i;
        logic signed [LP_W-1:0] q;
    } rxd_iq_t;
    typedef struct packed {
        logic signed [HP_W-1:0] i;
        logic signed [HP_W-1:0] q;
    } rxd_hp_t;
    typedef enum logic [1:0] {ST_STBY, ST_CAL_HP, ST_CAL_LP, ST_CALD} rxd_cal_t;
endpackage

/* File: rxd_chain.sv */
// Contract
// - Accept 5-bit high-performance converter samples
// - Accept 16-bit low-power converter samples
// - First stage decimates all rates to 184.32
// - 61.44 wideband only, 46.08 both modes
// - Wideband overall factor 2 to 32
// - Narrowband factor 160 to 1920 from 46.08
// - Divide-by-40 is /4 then /10
// - Lower-rate decimators individually enabled
// - Down-conversion only for IF, bypassed otherwise
// - Oscillator tunable 45 kHz to 21 MHz
// - Coarse estimate to analog, then residual digital
// - Residual notch width programmable, default 1/2048
// - Narrowband adaptive gain/phase before down-conversion
// - Wideband correction filter seeded, then adapted
// - Switching enabled: calibrate both converters
// - Converter switch compensates gain and latency
// - Down-conversion sits between decimation stages
`timescale 1ns/1ns
module rxd_chain
    import rxd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rxd_hp_t hp_sample,
    input wire rxd_iq_t lp_sample,
    input wire logic conv_valid,
    output rxd_iq_t out_iq,
    output logic out_valid,
    output rxd_iq_t coarse_dc_correction,
    output logic conv_active
);
    logic [7:0] ctrl, next_ctrl;
    logic [6:0] dec_en, next_dec_en;
    logic [31:0] ftw, next_ftw, nv32, next_rdata;
    logic [3:0] notch_sh, next_notch_sh, ws, next_ws;
    logic [15:0] qec_seed, next_qec_seed;
    logic flush, next_flush, aw_ok, next_aw_ok, w_ok, next_w_ok;
    logic [AXW-1:0] wa, next_wa;
    logic [31:0] wd, next_wd;
    logic next_bvalid, next_rvalid, do_wr, start_cal, seamless;
    logic [1:0] next_bresp, next_rresp;
    rxd_cal_t cal_st, next_cal_st;
    logic [CAL_LOG2-1:0] cal_cnt, next_cal_cnt;
    logic signed [LP_W+CAL_LOG2-1:0] cai, caq, next_cai, next_caq;
    rxd_iq_t ofs_hp, ofs_lp, next_ofs_hp, next_ofs_lp, hp_raw, cal_x;
    logic cal_done;
    rxd_iq_t fe, next_fe, qo, next_qo, nt, next_nt, dd, next_dd;
    logic fev, qv, ntv, ddv;
    logic signed [15:0] g, ph, w1, prev_i, next_g, next_ph, next_w1, next_prev_i;
    logic signed [31:0] dci, dcq, next_dci, next_dcq, pg, pp, pw, pc, ps, qc, qs;
    logic signed [15:0] yi, yq, sn, cs;
    logic [31:0] nco, next_nco, ftw_c;
    logic [3:0] fac [NSTG];
    logic en [NSTG];
    rxd_iq_t so [NSTG];
    logic sv [NSTG];

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                o[8*b +: 8] = d[8*b +: 8];
            end
        end
        return o;
    endfunction

    // Boxcar average by reciprocal multiply, avoids a divider
    function automatic logic signed [LP_W-1:0] avg(input logic signed [ACC_W-1:0] s,
                                                   input logic [3:0] f);
        logic signed [ACC_W+17:0] p;
        logic signed [17:0] r;
        case (f)
            4'h2: r = 18'sh08000;
            4'h3: r = 18'sh05555;
            4'h4: r = 18'sh04000;
            4'h6: r = 18'sh02AAB;
            4'h8: r = 18'sh02000;
            4'hA: r = 18'sh0199A;
            4'hC: r = 18'sh01555;
            default: r = 18'sh10000;
        endcase
        p = s * r;
        return p[LP_W+15:16];
    endfunction

    // Quarter-wave sine table, Q15, 16 phases
    function automatic logic signed [15:0] sin16(input logic [3:0] x);
        logic signed [15:0] m;
        case (x[2:0])
            3'h0: m = 16'sh0000;
            3'h1, 3'h7: m = 16'sh30FC;
            3'h2, 3'h6: m = 16'sh5A82;
            3'h3, 3'h5: m = 16'sh7642;
            default: m = 16'sh7FFF;
        endcase
        return x[3] ? -m : m;
    endfunction

    // Register bus: write and read channels with register side effects
    always_comb begin
        next_ctrl = ctrl;
        next_dec_en = dec_en;
        next_ftw = ftw;
        next_notch_sh = notch_sh;
        next_qec_seed = qec_seed;
        next_flush = 1'b0;
        start_cal = 1'b0;
        nv32 = 32'h0;
        seamless = ctrl[C_SWEN] & (cal_st == ST_CALD);
        next_aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
        next_w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
        next_wa = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : wa;
        next_wd = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd;
        next_ws = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws;
        do_wr = aw_ok & w_ok & ~s_axi_bvalid;
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        if (do_wr) begin
            next_aw_ok = 1'b0;
            next_w_ok = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OK;
            case (wa)
                A_CTRL: begin
                    nv32 = merge({24'h0, ctrl}, wd, ws);
                    next_ctrl = nv32[7:0];
                    next_ctrl[C_CAL] = 1'b0;
                    start_cal = nv32[C_CAL];
                    if (cal_st != ST_STBY) begin
                        next_ctrl[C_SWEN] = ctrl[C_SWEN];
                    end
                    // Seamless converter change keeps filter state
                    next_flush = (next_ctrl[C_CLK +: 2] != ctrl[C_CLK +: 2])
                        | (next_ctrl[C_R61:C_WB] != ctrl[C_R61:C_WB])
                        | (~seamless & (next_ctrl[C_CONV] != ctrl[C_CONV]));
                end
                A_DEC: begin
                    nv32 = merge({25'h0, dec_en}, wd, ws);
                    next_dec_en = nv32[6:0];
                    next_flush = (nv32[6:0] != dec_en);
                end
                A_NCO: next_ftw = merge(ftw, wd, ws);
                A_NOTCH: begin
                    nv32 = merge({28'h0, notch_sh}, wd, ws);
                    next_notch_sh = nv32[3:0];
                end
                A_QEC: begin
                    nv32 = merge({16'h0, qec_seed}, wd, ws);
                    next_qec_seed = nv32[15:0];
                end
                default: next_bresp = RESP_ERR;
            endcase
        end
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OK;
            case (s_axi_araddr)
                A_CTRL: next_rdata = {24'h0, ctrl};
                A_DEC: next_rdata = {25'h0, dec_en};
                A_NCO: next_rdata = ftw;
                A_NOTCH: next_rdata = {28'h0, notch_sh};
                A_QEC: next_rdata = {16'h0, qec_seed};
                A_STAT: next_rdata = {29'h0, ctrl[C_CONV], cal_st};
                A_CDC: next_rdata = coarse_dc_correction;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = RESP_ERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            dec_en <= DEC_RST;
            ftw <= FTW_MIN;
            notch_sh <= NOTCH_RST;
            qec_seed <= QEC_RST;
            flush <= 1'b0;
            {aw_ok, w_ok, wa, wd, ws} <= '0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} <= '0;
            {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata} <= '0;
        end else begin
            ctrl <= next_ctrl;
            dec_en <= next_dec_en;
            ftw <= next_ftw;
            notch_sh <= next_notch_sh;
            qec_seed <= next_qec_seed;
            flush <= next_flush;
            {aw_ok, w_ok, wa, wd, ws} <= {next_aw_ok, next_w_ok, next_wa, next_wd, next_ws};
            s_axi_awready <= ~next_aw_ok & ~next_bvalid;
            s_axi_wready <= ~next_w_ok & ~next_bvalid;
            {s_axi_bvalid, s_axi_bresp} <= {next_bvalid, next_bresp};
            s_axi_arready <= ~next_rvalid;
            {s_axi_rvalid, s_axi_rresp, s_axi_rdata} <= {next_rvalid, next_rresp, next_rdata};
        end
    end

    // HP word left-aligned so both converters share one gain
    assign hp_raw.i = {hp_sample.i, {HP_SHIFT{1'b0}}};
    assign hp_raw.q = {hp_sample.q, {HP_SHIFT{1'b0}}};
    assign cal_x = (cal_st == ST_CAL_HP) ? hp_raw : lp_sample;
    assign conv_active = ctrl[C_CONV];

    // Calibration: coarse DC estimate per converter
    always_comb begin
        next_cal_st = cal_st;
        next_cal_cnt = cal_cnt;
        next_cai = cai;
        next_caq = caq;
        next_ofs_hp = ofs_hp;
        next_ofs_lp = ofs_lp;
        cal_done = 1'b0;
        unique case (cal_st)
            ST_STBY, ST_CALD: begin
                if (start_cal) begin
                    next_cal_st = (next_ctrl[C_SWEN] | ~next_ctrl[C_CONV]) ?
                                  ST_CAL_HP : ST_CAL_LP;
                    {next_cal_cnt, next_cai, next_caq} = '0;
                end
            end
            ST_CAL_HP, ST_CAL_LP: begin
                if (conv_valid) begin
                    next_cai = cai + cal_x.i;
                    next_caq = caq + cal_x.q;
                    next_cal_cnt = cal_cnt + 1'b1;
                    if (&cal_cnt) begin
                        if (cal_st == ST_CAL_HP) begin
                            next_ofs_hp = {next_cai[LP_W+CAL_LOG2-1:CAL_LOG2],
                                           next_caq[LP_W+CAL_LOG2-1:CAL_LOG2]};
                        end else begin
                            next_ofs_lp = {next_cai[LP_W+CAL_LOG2-1:CAL_LOG2],
                                           next_caq[LP_W+CAL_LOG2-1:CAL_LOG2]};
                        end
                        {next_cai, next_caq} = '0;
                        next_cal_st = (cal_st == ST_CAL_HP && (ctrl[C_SWEN] | ctrl[C_CONV]))
                                      ? ST_CAL_LP : ST_CALD;
                        cal_done = (next_cal_st == ST_CALD);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_st <= ST_STBY;
            {cal_cnt, cai, caq, ofs_hp, ofs_lp} <= '0;
        end else begin
            cal_st <= next_cal_st;
            {cal_cnt, cai, caq} <= {next_cal_cnt, next_cai, next_caq};
            {ofs_hp, ofs_lp} <= {next_ofs_hp, next_ofs_lp};
        end
    end

    // Stage factors and enables from mode and clock selection
    always_comb begin
        unique case (ctrl[C_CLK +: 2])
            2'h1: fac[0] = F_CLK_M;
            2'h2: fac[0] = F_CLK_L;
            default: fac[0] = F_CLK_H;
        endcase
        en[0] = 1'b1;
        fac[1] = (ctrl[C_WB] & ctrl[C_R61]) ? F_61 : F_46;
        en[1] = 1'b1;
        fac[2] = F_10;
        en[2] = ~ctrl[C_WB];
        fac[3] = F_3;
        en[3] = ~ctrl[C_WB] & dec_en[0];
        for (int j = 0; j < 6; j++) begin
            fac[4+j] = F_2;
            // Wideband keeps 1..5 halvings, narrowband at least four
            en[4+j] = ctrl[C_WB] ? ((j == 0) | ((j < 5) & dec_en[j+1]))
                                 : ((j < 4) | dec_en[j+1]);
        end
    end

    // Front end, then QEC, residual notch and down-conversion
    always_comb begin
        next_fe = ctrl[C_CONV] ? lp_sample : hp_raw;
        pg = so[0].q * g;
        pp = so[0].i * ph;
        pw = prev_i * w1;
        next_qo.i = so[0].i;
        next_qo.q = so[0].q + pg[30:15] - pp[30:15]
                  - (ctrl[C_WB] ? pw[30:15] : 16'h0);
        {next_g, next_ph, next_w1, next_prev_i} = {g, ph, w1, prev_i};
        if (cal_done) begin
            next_g = ctrl[C_WB] ? {qec_seed[15:8], 8'h00} : 16'h0000;
            next_ph = ctrl[C_WB] ? {qec_seed[7:0], 8'h00} : 16'h0000;
            next_w1 = 16'h0000;
        end else if (sv[0]) begin
            // Sign-sign updates: slow but multiplier-free
            next_ph = ph + ((next_qo.q[15] ^ so[0].i[15]) ? -QEC_STEP : QEC_STEP);
            next_g = g + (((next_qo.q[15] ? -next_qo.q : next_qo.q)
                     < (so[0].i[15] ? -so[0].i : so[0].i)) ? QEC_STEP : -QEC_STEP);
            if (ctrl[C_WB]) begin
                next_w1 = w1 + ((next_qo.q[15] ^ prev_i[15]) ? -QEC_STEP : QEC_STEP);
            end
            next_prev_i = so[0].i;
        end
        yi = qo.i - dci[31:16];
        yq = qo.q - dcq[31:16];
        next_nt = {yi, yq};
        next_dci = qv ? dci + ($signed({yi, 16'h0000}) >>> notch_sh) : dci;
        next_dcq = qv ? dcq + ($signed({yq, 16'h0000}) >>> notch_sh) : dcq;
        ftw_c = (ftw < FTW_MIN) ? FTW_MIN : ((ftw > FTW_MAX) ? FTW_MAX : ftw);
        sn = sin16(nco[31:28]);
        cs = sin16(nco[31:28] + 4'h4);
        pc = nt.i * cs;
        ps = nt.q * sn;
        qc = nt.q * cs;
        qs = nt.i * sn;
        // Halved on mixing to leave headroom for the sum
        next_dd.i = 16'((33'(pc) + 33'(ps)) >>> 16);
        next_dd.q = 16'((33'(qc) - 33'(qs)) >>> 16);
        next_nco = ntv ? nco + ftw_c : nco;
        if (!ctrl[C_IF]) begin
            next_dd = nt;
            next_nco = 32'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {fe, fev, qo, qv, nt, ntv, dd, ddv} <= '0;
            {g, ph, w1, prev_i, dci, dcq, nco} <= '0;
        end else begin
            {fe, fev} <= {next_fe, conv_valid};
            {qo, qv} <= {next_qo, sv[0]};
            {nt, ntv} <= {next_nt, qv};
            {dd, ddv} <= {next_dd, ntv};
            {g, ph, w1, prev_i} <= {next_g, next_ph, next_w1, next_prev_i};
            {dci, dcq, nco} <= {next_dci, next_dcq, next_nco};
        end
    end

    // Decimator chain; stage 1 is fed from the down-converter
    for (genvar k = 0; k < NSTG; k++) begin : g_stg
        logic signed [ACC_W-1:0] ai, aq, next_ai, next_aq;
        logic [3:0] cnt, next_cnt;
        rxd_iq_t x, next_so;
        logic xv, next_sv;
        if (k == 0) begin : g_in
            assign {x, xv} = {fe, fev};
        end else if (k == 1) begin : g_in
            assign {x, xv} = {dd, ddv};
        end else begin : g_in
            assign {x, xv} = {so[k-1], sv[k-1]};
        end
        always_comb begin
            {next_ai, next_aq, next_cnt} = {ai, aq, cnt};
            next_so = so[k];
            next_sv = 1'b0;
            // Cleared with the setup write itself: old counts never meet new factors
            if (next_flush) begin
                {next_ai, next_aq, next_cnt} = '0;
            end else if (!en[k]) begin
                next_so = x;
                next_sv = xv;
            end else if (xv) begin
                next_ai = ai + x.i;
                next_aq = aq + x.q;
                next_cnt = cnt + 4'h1;
                if (cnt == fac[k] - 4'h1) begin
                    next_so = {avg(next_ai, fac[k]), avg(next_aq, fac[k])};
                    next_sv = 1'b1;
                    {next_ai, next_aq, next_cnt} = '0;
                end
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                {ai, aq, cnt, so[k], sv[k]} <= '0;
            end else begin
                {ai, aq, cnt, so[k], sv[k]} <= {next_ai, next_aq, next_cnt, next_so, next_sv};
            end
        end
    end

    // Output registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {out_iq, out_valid, coarse_dc_correction} <= '0;
        end else begin
            {out_iq, out_valid} <= {so[NSTG-1], sv[NSTG-1]};
            coarse_dc_correction <= ctrl[C_CONV] ? ofs_lp : ofs_hp;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_hp_path;
        conv_valid && !ctrl[C_CONV] |=> fev && fe.i == {$past(hp_sample.i), 11'h000};
    endproperty
    a_hp_path: assert property (p_hp_path) else $error("hp word misplaced");
    property p_lp_path;
        conv_valid && ctrl[C_CONV] |=> fev && fe == $past(lp_sample);
    endproperty
    a_lp_path: assert property (p_lp_path) else $error("lp word lost");
    property p_s0_cnt;
        g_stg[0].cnt < fac[0];
    endproperty
    a_s0_cnt: assert property (p_s0_cnt) else $error("stage0 overcount");
    property p_nb46;
        !ctrl[C_WB] |-> fac[1] == 4'h4;
    endproperty
    a_nb46: assert property (p_nb46) else $error("61.44 used in nb");
    property p_wb_casc;
        ctrl[C_WB] |-> !en[2] && !en[3] && en[4] && !en[9];
    endproperty
    a_wb_casc: assert property (p_wb_casc) else $error("wb factor range");
    property p_nb_casc;
        !ctrl[C_WB] |-> en[2] && en[4] && en[5] && en[6] && en[7];
    endproperty
    a_nb_casc: assert property (p_nb_casc) else $error("nb factor range");
    property p_zif;
        ntv && !ctrl[C_IF] |=> ddv && dd == $past(nt);
    endproperty
    a_zif: assert property (p_zif) else $error("zif not bypassed");
    property p_nco_step;
        ntv && ctrl[C_IF] |=> (nco - $past(nco)) >= FTW_MIN && (nco - $past(nco)) <= FTW_MAX;
    endproperty
    a_nco_step: assert property (p_nco_step) else $error("nco step out of range");
    property p_one_pulse;
        sv[0] |=> !sv[0];
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("stage0 strobe long");
    property p_flush;
        flush |-> g_stg[0].cnt == 4'h0 && !sv[0] && !sv[9];
    endproperty
    a_flush: assert property (p_flush) else $error("flush kept state");
    property p_swen;
        cal_st != ST_STBY |=> ctrl[C_SWEN] == $past(ctrl[C_SWEN]);
    endproperty
    a_swen: assert property (p_swen) else $error("swen changed late");
    c_out: cover property (out_valid);
    c_cald: cover property (cal_st == ST_CALD && ctrl[C_SWEN]);
    c_switch: cover property (cal_st == ST_CALD && $changed(ctrl[C_CONV]) && !flush);
endmodule

/* File: rxd_conv_model.sv */
`timescale 1ns/1ns
// Converter pair: one word each cycle while enabled, no back-pressure
module rxd_conv_model
    import rxd_pkg::*;
(
    input wire logic aclk,
    input wire logic en,
    output rxd_hp_t hp_sample = '0,
    output rxd_iq_t lp_sample = '0,
    output logic conv_valid = 1'b0
);
    logic [15:0] n = 16'h0000;
    // Ramp, so a stale word never passes for a fresh one
    always @(posedge aclk) begin
        n <= n + 16'h0001;
        conv_valid <= en;
        hp_sample <= {n[4:0], ~n[4:0]};
        lp_sample <= {n, ~n};
    end
endmodule

/* File: rxd_chain_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
$display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module rxd_chain_tb_top
    import rxd_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} rxd_row_t;
    logic aclk = 1'b0, aresetn = 1'b0, en = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, out_valid, conv_active, cv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r;
    rxd_hp_t hp;
    rxd_iq_t lp, out_iq, cdc;
    int n_errors = 0, n_compared = 0, g, i;
    // Plain cases: reset values, storage, refused places; only the oscillator clamps
    rxd_row_t rows [15] = '{'{1'b0, A_CTRL, 32'h0, RESP_OK}, '{1'b0, A_DEC, 32'h7F, RESP_OK},
        '{1'b0, A_NOTCH, 32'hB, RESP_OK}, '{1'b0, A_NCO, FTW_MIN, RESP_OK},
        '{1'b1, A_NCO, 32'hFFFFFFFF, RESP_OK}, '{1'b0, A_NCO, 32'hFFFFFFFF, RESP_OK},
        '{1'b1, A_NCO, 32'h1, RESP_OK}, '{1'b0, A_NCO, 32'h1, RESP_OK},
        '{1'b1, A_NOTCH, 32'h5, RESP_OK}, '{1'b0, A_NOTCH, 32'h5, RESP_OK},
        '{1'b1, A_STAT, 32'h0, RESP_ERR}, '{1'b0, 8'h1C, 32'h0, RESP_ERR},
        '{1'b1, 8'h1C, 32'h0, RESP_ERR}, '{1'b1, A_CTRL, 32'h1, RESP_OK},
        '{1'b0, A_STAT, 32'h4, RESP_OK}};
    always #20 aclk = ~aclk;
    rxd_conv_model u_conv (.aclk(aclk), .en(en), .hp_sample(hp), .lp_sample(lp), .conv_valid(cv));
    rxd_chain u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hp_sample(hp),
        .lp_sample(lp), .conv_valid(cv), .out_iq(out_iq), .out_valid(out_valid),
        .coarse_dc_correction(cdc), .conv_active(conv_active));
    // Write: each channel dropped at its own handshake, response awaited
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (bvalid === 1'b1) break;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        if (bvalid !== 1'b1) n_errors++;
        s = bresp;
        bready <= 1'b0;
    endtask
    // Read: rready held until rvalid is sampled high
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (100) begin
            @(posedge aclk);
            if (rvalid === 1'b1) break;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (rvalid !== 1'b1) n_errors++;
        v = rdata;
        s = rresp;
        rready <= 1'b0;
    endtask
    // Third gap counted; the first may span a flush
    task automatic gap(output int n);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (out_valid !== 1'b1 && n < 5000);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard, far above the thirteen thousand or so cycles the tests need
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        conclude();
    end
    initial begin
        en <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK({bvalid, rvalid, out_valid}, 3'h0)
        aresetn <= 1'b1;
        $display("reset test done");
        for (i = 0; i < 15; i++) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d, r);
            else rd(rows[i].a, d, r);
            `CHK(r, rows[i].r)
            if (!rows[i].w && r === RESP_OK) `CHK(d, rows[i].d)
        end
        `CHK(conv_active, 1'b1)
        // Byte lane 1 only: the other seed byte keeps its reset zero
        wstrb <= 4'h2;
        wr(A_QEC, 32'h0000AB12, r);
        wstrb <= 4'hF;
        rd(A_QEC, d, r);
        `CHK(d, 32'h0000AB00)
        $display("register rows done");
        // Wideband at 61.44, only the first halving stage: gap equals whole factor
        wr(A_DEC, 32'h2, r);
        wr(A_CTRL, 32'hA, r);
        `CHK(conv_active, 1'b0)
        gap(g);
        `CHK(g, int'(F_CLK_H) * F_61 * F_2)
        // Low-power path, one more halving stage doubles the gap
        wr(A_DEC, 32'h6, r);
        wr(A_CTRL, 32'hB, r);
        gap(g);
        `CHK(g, int'(F_CLK_H) * F_61 * F_2 * F_2)
        $display("decimation test done");
        // Switching enabled while still in standby, so both converters calibrate
        wr(A_CTRL, 32'h30, r);
        repeat (600) @(posedge aclk);
        rd(A_STAT, d, r);
        `CHK(d, 32'h3)
        // Switch enable frozen once calibrated
        wr(A_CTRL, 32'h0, r);
        rd(A_CTRL, d, r);
        `CHK(d, 32'h10)
        // Ramp hits every 5-bit code 8 times: mean of minus half a code, 0xFC00 left-aligned
        rd(A_CDC, d, r);
        `CHK(d, 32'hFC00FC00)
        `CHK(cdc, 32'hFC00FC00)
        $display("calibration test done");
        // Narrowband, slowest converter clock, down-conversion on
        wr(A_DEC, 32'h0, r);
        wr(A_CTRL, 32'h84, r);
        gap(g);
        `CHK(g, int'(F_CLK_L) * F_46 * F_10 * F_2 * F_2 * F_2 * F_2)
        $display("narrowband test done");
        // Second reset in mid-run brings the defaults back
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_STAT, d, r);
        `CHK(d, 32'h0)
        rd(A_NOTCH, d, r);
        `CHK(d, {28'h0, NOTCH_RST})
        $display("mid-run reset test done");
        conclude();
    end
endmodule
